//--- sgoc_fifo.sv
// Sample FIFO with registered read data and registered ready flag
`default_nettype none

module sgoc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Occupancy
  output logic [AW:0] level_o
);

  // DEPTH must be a power of two so the pointers wrap by themselves
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
    logic [WIDTH-1:0] dat;
  } sgoc_fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  sgoc_fifo_state_t st_reg, st_next;
  logic push, load;

  always_comb
  begin
    st_next = st_reg;
    push = in_valid_i && st_reg.rdy;
    load = (st_reg.cnt != '0) && (!st_reg.vld || out_ready_i);
    if (push)
    begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (load)
    begin
      st_next.rd = st_reg.rd + 1'b1;
      st_next.dat = mem[st_reg.rd];
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(load);
    // Ready sits in a flop of its own so the cores never see a
    // decoded compare on their handshake
    st_next.rdy = (st_next.cnt != (AW+1)'(DEPTH));
    st_next.vld = load || (st_reg.vld && !out_ready_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[st_reg.wr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '0;
      st_reg.rdy <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign in_ready_o = st_reg.rdy;
  assign out_valid_o = st_reg.vld;
  assign out_data_o = st_reg.dat;
  assign level_o = st_reg.cnt + (AW+1)'(st_reg.vld);

endmodule

`default_nettype wire

//--- sgoc_pkg.sv
// Package: constants and types of the sample gain/offset corrector
`default_nettype none

package sgoc_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SAMPLE_W = 14;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_W = 5;
  localparam int FRAC_W = 12;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_CONFIG3 = 8'h03;
  localparam logic [7:0] IDX_CH15_ODD = 8'h35;
  localparam logic [7:0] IDX_CH15_EVEN = 8'h36;
  localparam logic [7:0] IDX_CH16_ODD = 8'h37;
  localparam logic [7:0] IDX_CH16_EVEN = 8'h38;
  localparam logic [7:0] IDX_PAT_HPF = 8'h39;
  localparam logic [7:0] IDX_STATUS = 8'h3A;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CFG_GAIN_EN_BIT = 12;
  localparam int CFG_OFFSET_EN_BIT = 8;
  localparam int GAIN_LSB = 11;
  localparam int GAIN_MSB = 15;
  localparam int OFFSET_MSB = 9;
  localparam int HPF_EN_BIT = 0;
  localparam int HPF_CORNER_LSB = 1;
  localparam int HPF_CORNER_MSB = 4;
  localparam int PAT14_LSB = 6;
  localparam int PAT13_LSB = 9;
  localparam int PRBS_LSB = 12;
  localparam int STAT_VALID_BIT = 8;
  localparam int STAT_CORNER_BIT = 9;
  localparam logic [3:0] CORNER_MIN = 4'h2;
  localparam logic [3:0] CORNER_MAX = 4'hA;
  localparam logic [15:0] CORR_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // ----------------------------------------
  // Gain table: round(4096 * 10^(N * 0.2 / 20))
  // ----------------------------------------
  localparam logic [13:0] GAIN_UNITY = 14'h1000;
  localparam logic [13:0] GAIN_LUT [32] = '{
    14'h1000, 14'h105F, 14'h10C1, 14'h1125, 14'h118B, 14'h11F4,
    14'h125F, 14'h12CC, 14'h133C, 14'h13AF, 14'h1425, 14'h149D,
    14'h1518, 14'h1595, 14'h1616, 14'h169A, 14'h1721, 14'h17AA,
    14'h1838, 14'h18C8, 14'h195C, 14'h19F3, 14'h1A8E, 14'h1B2C,
    14'h1BCE, 14'h1C74, 14'h1D1D, 14'h1DCB, 14'h1E7D, 14'h1F33,
    14'h1FED, 14'h20AB};
  localparam logic signed [29:0] SAT_MAX = 30'sh00001FFF;
  localparam logic signed [29:0] SAT_MIN = 30'sh3FFFE000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic chan16;
    logic odd;
    logic [SAMPLE_W-1:0] data;
  } sgoc_sample_t;

  typedef struct packed {
    logic [3:0][15:0] corr;
    logic [15:0] pat_hpf;
    logic gain_en;
    logic off_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic out_valid;
    sgoc_sample_t out;
  } sgoc_state_t;

endpackage

`default_nettype wire

//--- sgoc_src_model.sv
// Converter-core sample source model for the corrector bench
`default_nettype none

module sgoc_src_model
  import sgoc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Handshake to the corrector
  input wire logic ready_i,
  output logic valid_o,
  output sgoc_sample_t smp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    valid_o = 1'b0;
    smp_o = '0;
  end

  // Offers one word; gives up after max_wait refused edges
  task automatic send(input sgoc_sample_t s, input int max_wait,
                      output bit ok);
    int n;
    @(posedge clk_i);
    valid_o <= 1'b1;
    smp_o <= s;
    n = 0;
    ok = 1'b0;
    do
    begin
      @(posedge clk_i);
      ok = (ready_i === 1'b1);
      n++;
    end
    while (!ok && n < max_wait);
    valid_o <= 1'b0;
    // Idle lines show the inverse word so a stale copy cannot match
    smp_o <= ~s;
  endtask
endmodule

`default_nettype wire

//--- sgoc_top.sv
// Gain/offset corrector for converter channels 15 and 16, APB slave
`default_nettype none

module sgoc_top
  import sgoc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Samples from the converter cores
  input wire logic smp_valid_i,
  output logic smp_ready_o,
  input wire sgoc_sample_t smp_i,
  // Corrected samples
  output logic cor_valid_o,
  input wire logic cor_ready_i,
  output sgoc_sample_t cor_o,
  // Filter and pattern controls
  output logic highpass_enable_upper_group_o,
  output logic [3:0] highpass_corner_upper_group_o,
  output logic [3:0] prbs_select_o,
  output logic [2:0] pattern_select_out13_o,
  output logic [2:0] pattern_select_out14_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sgoc_state_t st, nx;
  logic f_valid, f_ready;
  sgoc_sample_t f_data;
  logic [FIFO_LVL_W-1:0] f_level;
  logic setup, access, aligned, hit;
  logic [7:0] idx;
  logic [31:0] rd_data;
  logic [1:0] slot;
  logic [15:0] cr;
  logic [3:0] corner;
  logic corner_bad;
  logic signed [14:0] off, diff;
  logic [13:0] gain;
  logic signed [29:0] prod, scaled;
  logic [13:0] res;

  // ----------------------------------------
  // Input buffer
  // ----------------------------------------
  // Absorbs converter bursts while the consumer stalls; a full
  // buffer drops ready towards the cores
  sgoc_fifo #(
    .WIDTH($bits(sgoc_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(smp_valid_i),
    .in_ready_o(smp_ready_o),
    .in_data_i(smp_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data),
    .level_o(f_level)
  );

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  always_comb
  begin
    setup = psel_i && !penable_i;
    access = psel_i && penable_i && st.pready;
    idx = paddr_i[9:2];
    aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
    corner = st.pat_hpf[HPF_CORNER_MSB:HPF_CORNER_LSB];
    corner_bad = st.pat_hpf[HPF_EN_BIT]
      && ((corner < CORNER_MIN) || (corner > CORNER_MAX));
    hit = aligned;
    rd_data = UNMAPPED_READ;
    case (idx)
      IDX_CONFIG3:
      begin
        rd_data[CFG_GAIN_EN_BIT] = st.gain_en;
        rd_data[CFG_OFFSET_EN_BIT] = st.off_en;
      end
      IDX_CH15_EVEN: rd_data[15:0] = st.corr[0];
      IDX_CH15_ODD: rd_data[15:0] = st.corr[1];
      IDX_CH16_EVEN: rd_data[15:0] = st.corr[2];
      IDX_CH16_ODD: rd_data[15:0] = st.corr[3];
      IDX_PAT_HPF: rd_data[15:0] = st.pat_hpf;
      IDX_STATUS:
      begin
        rd_data[FIFO_LVL_W-1:0] = f_level;
        rd_data[STAT_VALID_BIT] = st.out_valid;
        rd_data[STAT_CORNER_BIT] = corner_bad;
      end
      default: hit = 1'b0;
    endcase
    if (!aligned)
    begin
      rd_data = UNMAPPED_READ;
    end
  end

  // ----------------------------------------
  // Correction datapath
  // ----------------------------------------
  always_comb
  begin
    slot = {f_data.chan16, f_data.odd};
    cr = st.corr[slot];
    off = st.off_en ? {{5{cr[OFFSET_MSB]}}, cr[OFFSET_MSB:0]} : '0;
    diff = $signed({f_data.data[13], f_data.data}) - off;
    gain = st.gain_en ? GAIN_LUT[cr[GAIN_MSB:GAIN_LSB]] : GAIN_UNITY;
    prod = diff * $signed({1'b0, gain});
    scaled = prod >>> FRAC_W;
    // Saturate instead of wrapping: a wrapped full-scale sample
    // would show up as a spike of the opposite sign
    if (scaled > SAT_MAX)
    begin
      res = SAT_MAX[13:0];
    end
    else if (scaled < SAT_MIN)
    begin
      res = SAT_MIN[13:0];
    end
    else
    begin
      res = scaled[13:0];
    end
    f_ready = !st.out_valid || cor_ready_i;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nx = st;
    // No wait state: ready and read data are registered at the setup edge, so read data come from a flop
    nx.pready = setup;
    nx.pslverr = setup && !hit;
    if (setup)
    begin
      nx.prdata = rd_data;
    end
    if (access && pwrite_i && hit)
    begin
      case (idx)
        IDX_CONFIG3:
        begin
          nx.gain_en = pwdata_i[CFG_GAIN_EN_BIT];
          nx.off_en = pwdata_i[CFG_OFFSET_EN_BIT];
        end
        IDX_CH15_EVEN: nx.corr[0] = pwdata_i[15:0];
        IDX_CH15_ODD: nx.corr[1] = pwdata_i[15:0];
        IDX_CH16_EVEN: nx.corr[2] = pwdata_i[15:0];
        IDX_CH16_ODD: nx.corr[3] = pwdata_i[15:0];
        IDX_PAT_HPF: nx.pat_hpf = pwdata_i[15:0];
        default: nx.out_valid = st.out_valid;
      endcase
    end
    // unity gain and zero offset pass through
    if (f_valid && f_ready)
    begin
      nx.out_valid = 1'b1;
      nx.out.chan16 = f_data.chan16;
      nx.out.odd = f_data.odd;
      nx.out.data = res;
    end
    else if (cor_ready_i)
    begin
      nx.out_valid = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.corr <= {4{CORR_RESET}};
      st.pat_hpf <= CORR_RESET;
    end
    else
    begin
      st <= nx;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign cor_valid_o = st.out_valid;
  assign cor_o = st.out;
  assign highpass_enable_upper_group_o = st.pat_hpf[HPF_EN_BIT];
  assign highpass_corner_upper_group_o = corner_reg_view();
  assign prbs_select_o = st.pat_hpf[PRBS_LSB+3:PRBS_LSB];
  assign pattern_select_out13_o = st.pat_hpf[PAT13_LSB+2:PAT13_LSB];
  assign pattern_select_out14_o = st.pat_hpf[PAT14_LSB+2:PAT14_LSB];

  function automatic logic [3:0] corner_reg_view();
    return st.pat_hpf[HPF_CORNER_MSB:HPF_CORNER_LSB];
  endfunction

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic take;
  assign take = f_valid && f_ready;

  a_apb_ready_pulse: assert property (
    setup |=> pready_o ##1 !pready_o)
    else $error("pready is not a single cycle after setup");

  a_apb_unmapped: assert property (
    setup && !aligned |=> pslverr_o && prdata_o == UNMAPPED_READ)
    else $error("unaligned access not refused");

  a_reg_write_read: assert property (
    access && pwrite_i && paddr_i == {2'b00, IDX_CH16_ODD, 2'b00}
    |=> st.corr[3] == $past(pwdata_i[15:0]))
    else $error("correction register did not store the write");

  a_hpf_follow: assert property (
    access && pwrite_i && paddr_i == {2'b00, IDX_PAT_HPF, 2'b00}
    |=> highpass_enable_upper_group_o == $past(pwdata_i[HPF_EN_BIT]))
    else $error("filter enable does not follow its bit");

  a_bypass_exact: assert property (
    take && !st.gain_en && !st.off_en
    |=> cor_valid_o && cor_o == $past(f_data))
    else $error("disabled correction changed a sample");

  a_offset_sub: assert property (
    take && !st.gain_en && st.off_en && f_data.data[13:12] == 2'b00
    |=> $signed(cor_o.data) == $signed({2'b00, $past(f_data.data[11:0])})
      - $signed($past(cr[OFFSET_MSB:0])))
    else $error("offset not subtracted as twos complement");

  a_gain_six_db: assert property (
    take && st.gain_en && !st.off_en && f_data.data == 14'h0400
    && cr[GAIN_MSB:GAIN_LSB] == 5'h1E
    |=> cor_o.data == 14'h07FB)
    else $error("gain of 6.0 dB not applied");

  a_gain_disabled: assert property (
    take && !st.gain_en && !st.off_en && cr[GAIN_MSB:GAIN_LSB] != 5'h00
    |=> cor_o.data == $past(f_data.data))
    else $error("gain field used while gain disabled");

  a_out_hold: assert property (
    cor_valid_o && !cor_ready_i |=> cor_valid_o && $stable(cor_o))
    else $error("stalled output sample changed");

  a_mapped_no_error: assert property (
    setup && hit |=> !pslverr_o)
    else $error("mapped access flagged as error");

  a_unmapped_write_drop: assert property (
    access && pwrite_i && !hit
    |=> $stable(st.corr) && $stable(st.pat_hpf) && $stable(st.gain_en))
    else $error("refused write changed a register");

  a_corr_write_only: assert property (
    !(access && pwrite_i) |=> $stable(st.corr))
    else $error("correction register changed without a write");

  a_hpf_write_only: assert property (
    !(access && pwrite_i) |=> $stable(highpass_enable_upper_group_o))
    else $error("filter enable changed without a write");

  a_gain_enable_bit: assert property (
    access && pwrite_i && paddr_i == {2'b00, IDX_CONFIG3, 2'b00}
    |=> st.gain_en == $past(pwdata_i[CFG_GAIN_EN_BIT]))
    else $error("gain enable does not follow its bit");

  a_offset_enable_bit: assert property (
    access && pwrite_i && paddr_i == {2'b00, IDX_CONFIG3, 2'b00}
    |=> st.off_en == $past(pwdata_i[CFG_OFFSET_EN_BIT]))
    else $error("offset enable does not follow its bit");

  // No write can commit on a setup edge, so the enables seen one
  // cycle later are the ones that were captured
  a_config_readback: assert property (
    setup && !pwrite_i && paddr_i == {2'b00, IDX_CONFIG3, 2'b00}
    |=> prdata_o[CFG_GAIN_EN_BIT] == st.gain_en
      && prdata_o[CFG_OFFSET_EN_BIT] == st.off_en)
    else $error("enable bits not read back");

  a_gain_max: assert property (
    take && st.gain_en && !st.off_en && f_data.data == 14'h0400
    && cr[GAIN_MSB:GAIN_LSB] == 5'h1F
    |=> cor_o.data == 14'h082A)
    else $error("gain of 6.2 dB not applied");

  a_odd_ch16_offset: assert property (
    take && !st.gain_en && st.off_en && f_data.chan16 && f_data.odd
    && f_data.data[13:12] == 2'b00
    |=> $signed(cor_o.data) == $signed({2'b00, $past(f_data.data[11:0])})
      - $signed($past(st.corr[3][OFFSET_MSB:0])))
    else $error("odd channel 16 sample used a foreign offset");

  c_gain_sample: cover property (take && st.gain_en && st.off_en);
  c_fifo_full: cover property (!smp_ready_o && smp_valid_i);
  c_unmapped: cover property (setup && !hit);
  c_odd_ch16: cover property (take && f_data.odd && f_data.chan16);
  c_saturate: cover property (take && (scaled > SAT_MAX));

endmodule

`default_nettype wire

//--- tb_sample_gain_offset_correction.sv
// Self-checking bench of the sample gain/offset corrector
`default_nettype none

module tb_sample_gain_offset_correction
  import sgoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_i;
  logic rst_n_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic smp_valid;
  logic smp_ready;
  sgoc_sample_t smp;
  logic cor_valid_o;
  logic cor_ready_i;
  sgoc_sample_t cor_o;
  logic hp_en;
  logic [3:0] hp_corner;
  logic [3:0] prbs;
  logic [2:0] pat13;
  logic [2:0] pat14;
  int failures;
  int checks;
  logic [15:0] mirror [4];
  logic gen;
  logic oen;
  bit stall;
  sgoc_sample_t expq [$];

  sgoc_top i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .smp_valid_i(smp_valid), .smp_ready_o(smp_ready), .smp_i(smp),
    .cor_valid_o(cor_valid_o), .cor_ready_i(cor_ready_i), .cor_o(cor_o),
    .highpass_enable_upper_group_o(hp_en),
    .highpass_corner_upper_group_o(hp_corner),
    .prbs_select_o(prbs), .pattern_select_out13_o(pat13),
    .pattern_select_out14_o(pat14)
  );

  sgoc_src_model i_src (
    .clk_i(mclk_i), .ready_i(smp_ready), .valid_o(smp_valid), .smp_o(smp)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic summarize;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout(input string what);
    failures++;
    $display("MISMATCH t=%0t timeout %s", $time, what);
    summarize();
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1)
      timeout("apb");
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x, "read data");
    check(32'(e), 32'(xe), "read error");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic setc(input int i, input logic [15:0] v);
    wr(12'h0D4 + 12'(4 * i), 32'(v));
    mirror[i] = v;
  endtask

  task automatic cfg(input logic g, input logic o);
    wr(12'h00C, {19'h0, g, 3'h0, o, 8'h00});
    gen = g;
    oen = o;
  endtask

  // ----------------------------------------
  // Reference model of the correction
  // ----------------------------------------
  function automatic logic [13:0] ref_out(input sgoc_sample_t s);
    logic [15:0] c;
    int g;
    int p;
    c = mirror[{s.chan16, ~s.odd}];
    g = gen ? $rtoi(4096.0 * (10.0 ** (c[15:11] / 100.0)) + 0.5) : 4096;
    p = int'($signed(s.data)) - (oen ? int'($signed(c[9:0])) : 0);
    p = (p * g) >>> 12;
    if (p > 8191)
      p = 8191;
    if (p < -8192)
      p = -8192;
    return p[13:0];
  endfunction

  task automatic put(input sgoc_sample_t s, input int mw, output bit ok);
    sgoc_sample_t e;
    i_src.send(s, mw, ok);
    e = s;
    e.data = ref_out(s);
    if (ok)
      expq.push_back(e);
  endtask

  task automatic drain;
    int n;
    for (n = 0; n < 400 && expq.size() != 0; n++)
      @(posedge mclk_i);
    if (expq.size() != 0)
      timeout("drain");
  endtask

  task automatic stream(input int cnt);
    bit ok;
    repeat (cnt)
    begin
      put(sgoc_sample_t'(16'($urandom)), 50, ok);
      if (!ok)
        timeout("sample");
    end
    drain();
  endtask

  always @(posedge mclk_i)
    cor_ready_i <= !stall && ($urandom_range(3) != 0);

  always @(posedge mclk_i)
    if (rst_n_i === 1'b1 && cor_valid_o === 1'b1 && cor_ready_i === 1'b1)
      check(32'(cor_o), expq.size() != 0 ? 32'(expq.pop_front()) :
            32'hFFFFFFFF, "sample");

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] v;
    bit ok;
    int n;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {rst_n_i, gen, oen, stall} = '0;
    failures = 0;
    checks = 0;
    void'($urandom(98));
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(12'h00C, 32'h0, 1'b0);
    // A refused unaligned write must leave every register at zero
    wr(12'h0D6, 32'h0000FFFF);
    for (int i = 0; i < 6; i++)
      rd(12'h0D4 + 12'(4 * i), 32'h0, 1'b0);
    check(32'(hp_en), 32'h0, "filter enable");
    rd(12'h100, 32'h0, 1'b1);
    rd(12'h0D6, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      // Bit 10 is written as zero
      setc(i, 16'($urandom) & 16'hFBFF);
      rd(12'h0D4 + 12'(4 * i), 32'(mirror[i]), 1'b0);
    end
    for (int k = 0; k < 2; k++)
    begin
      // Corner kept in 2..10, bit 5 zero
      v = (16'($urandom) & 16'hFFC0) | 16'((2 + $urandom_range(8)) << 1);
      v[0] = k[0];
      wr(12'h0E4, 32'(v));
      rd(12'h0E4, 32'(v), 1'b0);
      check(32'({prbs, pat13, pat14, hp_corner, hp_en}),
            32'({v[15:6], v[4:0]}), "filter ctrl");
    end
    cfg(1'b0, 1'b0);
    stream(20);
    for (int m = 1; m < 4; m++)
    begin
      cfg(m[1], m[0]);
      rd(12'h00C, {19'h0, m[1], 3'h0, m[0], 8'h00}, 1'b0);
      for (int i = 0; i < 4; i++)
        setc(i, 16'($urandom) & 16'hFBFF);
      stream(24);
    end
    for (int g = 0; g < 32; g++)
    begin
      // Most negative offset drives the saturation corner
      setc(1, {g[4:0], 1'b0, 10'h200});
      put({2'b00, 14'($urandom)}, 50, ok);
      if (!ok)
        timeout("sample");
      drain();
    end
    cfg(1'b1, 1'b0);
    for (int g = 30; g < 32; g++)
    begin
      // Exact 6.0 and 6.2 dB steps on an eighth-scale sample
      setc(1, {g[4:0], 11'h000});
      put({2'b00, 14'h0400}, 50, ok);
      if (!ok)
        timeout("sample");
      drain();
    end
    stall = 1'b1;
    n = 0;
    do
    begin
      put(sgoc_sample_t'(16'($urandom)), 3, ok);
      n += ok;
    end
    while (ok && n < 40);
    check(32'(n >= FIFO_DEPTH && n < 40), 32'h1, "fifo fill");
    check(32'(smp_ready), 32'h0, "fifo full");
    // Full buffer: all stored words plus the loaded output word
    rd(12'h0E8, 32'h100 | 32'(FIFO_DEPTH + 1), 1'b0);
    stall = 1'b0;
    drain();
    summarize();
  end
endmodule

`default_nettype wire
